// ### rtl/uag_pkg.sv
// Behaviour
// - Software sets speaker volume anywhere from +6 dB down to -32 dB.
// - Speaker mute bit low silences playback; high plays at programmed volume.
// - Volume register at 1CH: code in bits 0-6, active-low mute bit 7, reset 0.
// - Volume code is 7-bit two's complement; 0.5 dB steps to -12 dB, 1 dB below.
// - Six-bit mic gain field in bits 0-5 gives 0 to 19.5 dB.
// - Mic gain scales the 16-bit converter samples before recording.
// - Gain rises 0.5 dB per code to 19.5 dB; codes 100111 and above hold 19.5 dB.
// - Bit 6 of the mic gain register always reads zero.
// - Mic mute bit 7 low mutes the microphone; high records normally.
// - Writing the record low byte only loads an 8-bit holding buffer.
// - Writing the record high byte pushes held low and new high as one sample.
package uag_pkg;

  // Register offsets
  localparam logic [7:0] SPK_VOL_OFS  = 8'h1C;
  localparam logic [7:0] MIC_GAIN_OFS = 8'h30;
  localparam logic [7:0] REC_LO_OFS   = 8'h31;
  localparam logic [7:0] REC_HI_OFS   = 8'h32;
  localparam logic [7:0] PUSH_CNT_OFS = 8'h33;

  // Reset values
  localparam logic [7:0] SPK_VOL_RST  = 8'h00;
  localparam logic [7:0] MIC_GAIN_RST = 8'h00;

  // Field positions
  localparam int unsigned MUTE_BIT   = 7;
  localparam int unsigned UNUSED_BIT = 6;

  // Volume and gain code limits
  localparam logic [6:0] VOL_MAX      = 7'h0C;
  localparam logic [6:0] VOL_FINE_MIN = 7'h68;
  localparam logic [6:0] VOL_MIN      = 7'h54;
  localparam logic [5:0] MIC_CODE_MAX = 6'h27;

  // Gain arithmetic: Q14 step table, twelve half-dB steps per octave
  localparam logic [7:0] HALF_DB_BIAS = 8'h48;
  localparam logic [7:0] OCT_STEPS    = 8'h0C;
  localparam logic [5:0] GAIN_SHIFT   = 6'h14;
  localparam logic signed [15:0] SMP_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SMP_MIN = -16'sh8000;

  // One audio sample with its valid strobe
  typedef struct packed {
    logic               vld;
    logic signed [15:0] data;
  } uag_smp_s;

  // Register state of the gain and mute path
  typedef struct packed {
    logic [7:0] spk_vol;
    logic [7:0] mic_ctrl;
    logic [7:0] rec_lo;
    logic [7:0] rd_data;
    uag_smp_s   iso;
    logic [7:0] push_cnt;
  } uag_regs_s;

  // Linear factor of r half-dB steps within one octave, Q14
  function automatic logic [15:0] uag_step_mult(input logic [3:0] r);
    case (r)
      4'h0:    return 16'h4000;
      4'h1:    return 16'h43CE;
      4'h2:    return 16'h47D6;
      4'h3:    return 16'h4C1C;
      4'h4:    return 16'h50A3;
      4'h5:    return 16'h556E;
      4'h6:    return 16'h5A82;
      4'h7:    return 16'h5FE4;
      4'h8:    return 16'h6598;
      4'h9:    return 16'h6BA2;
      4'hA:    return 16'h7209;
      4'hB:    return 16'h78D1;
      default: return 16'h4000;
    endcase
  endfunction : uag_step_mult

endpackage : uag_pkg

// ### rtl/uag_gain_stage.sv
`timescale 1ns/1ps
`default_nettype none
module uag_gain_stage
  import uag_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Gain setting in signed half-dB units, and mute
  input  wire logic signed [7:0]  half_db,
  input  wire logic               mute,
  // Sample stream
  input  wire uag_smp_s           smp_in,
  output var  uag_smp_s           smp_out
);

  uag_smp_s st_q;
  uag_smp_s st_d;

  logic        [7:0]  biased;
  logic        [3:0]  oct;
  logic        [3:0]  step;
  logic signed [32:0] prod;
  logic signed [47:0] scaled;

  // Split gain into octave shift and in-octave step; one cycle latency
  always_comb begin
    biased = 8'(half_db + signed'(HALF_DB_BIAS));
    oct    = 4'(biased / OCT_STEPS);
    step   = 4'(biased % OCT_STEPS);
    prod   = smp_in.data * signed'({1'b0, uag_step_mult(step)});
    scaled = (48'(prod) <<< oct) >>> GAIN_SHIFT;
    st_d.vld = smp_in.vld;
    if (mute) begin
      st_d.data = '0;
    end else if (scaled > 48'(SMP_MAX)) begin
      st_d.data = SMP_MAX;
    end else if (scaled < 48'(SMP_MIN)) begin
      st_d.data = SMP_MIN;
    end else begin
      st_d.data = 16'(scaled);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign smp_out = st_q;

  // Positive gain never flips the sign of a sample
  a_sat_sign: assert property (@(posedge mclk) disable iff (sys_rst)
    (smp_in.vld && !mute && half_db >= 0 && smp_in.data > 0) |=> st_q.data > 0)
    else $error("gain stage wrapped a positive sample");

  c_saturate: cover property (@(posedge mclk) disable iff (sys_rst)
    smp_in.vld && !mute && scaled > 48'(SMP_MAX));

endmodule : uag_gain_stage
`default_nettype wire

// ### rtl/uag_gain_path.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module uag_gain_path
  import uag_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Playback stream from the USB OUT pipe to the speaker
  input  wire uag_smp_s   spk_in,
  output var  uag_smp_s   spk_out,
  // Record stream from the converter, after gain
  input  wire uag_smp_s   adc_in,
  output var  uag_smp_s   mic_out,
  // Firmware sample into the isochronous IN buffer
  output var  uag_smp_s   iso_in
);

  uag_regs_s st_q;
  uag_regs_s st_d;

  logic signed [7:0] spk_half_db;
  logic signed [7:0] mic_half_db;
  logic              wr_vol;
  logic              wr_mic;
  logic              wr_lo;
  logic              wr_hi;

  // Volume code to signed half-dB units; out-of-table codes clamp
  function automatic logic signed [7:0] vol_to_half_db(input logic [6:0] c);
    logic signed [7:0] v;
    logic signed [7:0] top;
    logic signed [7:0] fine;
    logic signed [7:0] low;
    v    = signed'({c[6], c});
    top  = signed'({VOL_MAX[6], VOL_MAX});
    fine = signed'({VOL_FINE_MIN[6], VOL_FINE_MIN});
    low  = signed'({VOL_MIN[6], VOL_MIN});
    if (v > top) begin
      return top;
    end else if (v >= fine) begin
      return v;
    end else if (v >= low) begin
      return (v <<< 1) - fine;
    end else begin
      return (low <<< 1) - fine;
    end
  endfunction : vol_to_half_db

  // Mic code to half-dB units, flat above the top code
  function automatic logic signed [7:0] mic_to_half_db(input logic [5:0] c);
    if (c > MIC_CODE_MAX) begin
      return signed'({2'h0, MIC_CODE_MAX});
    end else begin
      return signed'({2'h0, c});
    end
  endfunction : mic_to_half_db

  // Write decode
  assign wr_vol = reg_wr && (reg_addr == SPK_VOL_OFS);
  assign wr_mic = reg_wr && (reg_addr == MIC_GAIN_OFS);
  assign wr_lo  = reg_wr && (reg_addr == REC_LO_OFS);
  assign wr_hi  = reg_wr && (reg_addr == REC_HI_OFS);

  assign spk_half_db = vol_to_half_db(st_q.spk_vol[6:0]);
  assign mic_half_db = mic_to_half_db(st_q.mic_ctrl[5:0]);

  // Next state of registers, read data and IN-buffer push
  always_comb begin
    st_d = st_q;
    if (wr_vol) begin
      st_d.spk_vol = reg_wdata;
    end
    if (wr_mic) begin
      st_d.mic_ctrl = reg_wdata;
      st_d.mic_ctrl[UNUSED_BIT] = 1'b0;
    end
    // Low byte only waits here; nothing reaches the buffer
    if (wr_lo) begin
      st_d.rec_lo = reg_wdata;
    end
    // High byte completes the sample and pushes it in one go
    st_d.iso.vld = wr_hi;
    if (wr_hi) begin
      st_d.iso.data = signed'({reg_wdata, st_q.rec_lo});
      st_d.push_cnt = 8'(st_q.push_cnt + 8'h01);
    end
    // Read data stands one cycle only; unmapped reads give zero
    st_d.rd_data = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        SPK_VOL_OFS:  st_d.rd_data = st_q.spk_vol;
        MIC_GAIN_OFS: st_d.rd_data = st_q.mic_ctrl;
        REC_LO_OFS:   st_d.rd_data = st_q.rec_lo;
        PUSH_CNT_OFS: st_d.rd_data = st_q.push_cnt;
        default:      st_d.rd_data = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q          <= '0;
      st_q.spk_vol  <= SPK_VOL_RST;
      st_q.mic_ctrl <= MIC_GAIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rd_data;
  assign iso_in    = st_q.iso;

  // Playback volume; active-low mute bit zeroes output
  uag_gain_stage u_spk_gain (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .half_db (spk_half_db),
    .mute    (!st_q.spk_vol[MUTE_BIT]),
    .smp_in  (spk_in),
    .smp_out (spk_out)
  );

  // Record gain on converter samples; same active-low mute
  uag_gain_stage u_mic_gain (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .half_db (mic_half_db),
    .mute    (!st_q.mic_ctrl[MUTE_BIT]),
    .smp_in  (adc_in),
    .smp_out (mic_out)
  );

  // Checks run in the single clock domain
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Checked on the first edge out of reset, where the disable no longer masks it
  a_vol_reset_zero: assert property (@(posedge mclk)
    $fell(sys_rst) |-> st_q.spk_vol == 8'h00 && st_q.mic_ctrl[MUTE_BIT] == 1'b0)
    else $error("volume register not zero after reset");

  a_vol_range: assert property (
    spk_half_db <= 8'sh0C && spk_half_db >= -8'sh40)
    else $error("speaker gain outside +6 to -32 dB");

  a_vol_coarse: assert property (
    st_q.spk_vol[6:0] == VOL_MIN |-> spk_half_db == -8'sh40)
    else $error("lowest volume code is not -32 dB");

  a_spk_muted: assert property (
    spk_in.vld && !st_q.spk_vol[MUTE_BIT] && !wr_vol |=> spk_out.vld && spk_out.data == 16'h0000)
    else $error("speaker not silenced while muted");

  a_spk_unity: assert property (
    spk_in.vld && st_q.spk_vol == 8'h80 && !wr_vol |=> spk_out.data == $past(spk_in.data))
    else $error("0 dB playback altered the sample");

  a_mic_clamp: assert property (
    st_q.mic_ctrl[5:0] >= MIC_CODE_MAX |-> mic_half_db == 8'sh27)
    else $error("mic gain above 19.5 dB");

  a_mic_muted: assert property (
    adc_in.vld && !st_q.mic_ctrl[MUTE_BIT] && !wr_mic |=> mic_out.data == 16'h0000)
    else $error("microphone not muted");

  a_mic_unity: assert property (
    adc_in.vld && st_q.mic_ctrl == 8'h80 && !wr_mic |=> mic_out.data == $past(adc_in.data))
    else $error("0 dB record altered the sample");

  a_mic_bit6_zero: assert property (
    reg_rd && reg_addr == MIC_GAIN_OFS |=> reg_rdata[UNUSED_BIT] == 1'b0)
    else $error("unused mic bit read as one");

  a_lo_no_push: assert property (
    wr_lo |=> !iso_in.vld)
    else $error("low byte write reached the IN buffer");

  a_hi_push: assert property (
    wr_lo ##1 wr_hi |=> iso_in.vld && iso_in.data == {$past(reg_wdata), $past(reg_wdata, 2)})
    else $error("high byte write did not push the paired sample");

  a_rd_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data held past its cycle");

  c_sample_pair: cover property (wr_lo ##1 wr_hi);
  c_spk_mute: cover property (spk_in.vld && !st_q.spk_vol[MUTE_BIT]);
  c_vol_coarse: cover property (spk_in.vld && spk_half_db < -8'sh18);
  c_mic_max: cover property (adc_in.vld && st_q.mic_ctrl[5:0] == 6'h3F);

endmodule : uag_gain_path
`default_nettype wire

// ### sim/uag_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uag_host_model
  import uag_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Sample request from the bench
  input  wire logic        send,
  input  wire logic [15:0] send_data,
  // Isochronous pipes
  output var  uag_smp_s    spk_smp,
  input  wire uag_smp_s    iso_smp,
  // Collected IN samples
  output logic      [15:0] iso_last,
  output logic      [7:0]  iso_cnt
);
  // OUT pipe; idle data toggles so a stale sample is never trusted
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      spk_smp <= '0;
    end else begin
      spk_smp.vld  <= send;
      spk_smp.data <= send ? send_data : ~spk_smp.data;
    end
  end

  // IN pipe sink, one sample per strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      iso_cnt  <= 8'h00;
      iso_last <= 16'h0000;
    end else if (iso_smp.vld) begin
      iso_cnt  <= iso_cnt + 8'h01;
      iso_last <= iso_smp.data;
    end
  end
endmodule : uag_host_model
`default_nettype wire

// ### sim/test_usb_audio_gain_mute_path.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_audio_gain_mute_path;
  import uag_pkg::*;
  logic        mclk, sys_rst, reg_wr, reg_rd, send;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, iso_cnt;
  logic [15:0] send_data, iso_last;
  uag_smp_s    spk_in, spk_out, adc_in, mic_out, iso_in;
  int          fail_count = 0;
  int          checked = 0;

  uag_gain_path dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spk_in(spk_in), .spk_out(spk_out),
    .adc_in(adc_in), .mic_out(mic_out), .iso_in(iso_in));
  uag_host_model host (.mclk(mclk), .sys_rst(sys_rst), .send(send), .send_data(send_data),
    .spk_smp(spk_in), .iso_smp(iso_in), .iso_last(iso_last), .iso_cnt(iso_cnt));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {9'h000, e}, {9'h000, reg_rdata});
    @(posedge mclk);
  endtask : rd_chk

  // Host sample two edges ahead of the output: model register plus gain stage
  task automatic spk(input logic [7:0] v, input logic [15:0] x, input logic [15:0] e);
    wr(SPK_VOL_OFS, v);
    send      <= 1'b1;
    send_data <= x;
    @(posedge mclk);
    send <= 1'b0;
    @(posedge mclk);
    #1 chk("spk_out", {1'b1, e}, spk_out);
    @(posedge mclk);
  endtask : spk

  task automatic mic(input logic [7:0] v, input logic [15:0] x, input logic [15:0] e);
    wr(MIC_GAIN_OFS, v);
    adc_in <= '{1'b1, x};
    @(posedge mclk);
    adc_in <= '{1'b0, ~x};
    #1 chk("mic_out", {1'b1, e}, mic_out);
    @(posedge mclk);
  endtask : mic

  task automatic t_regs;
    rd_chk(SPK_VOL_OFS, 8'h00);
    rd_chk(MIC_GAIN_OFS, 8'h00);
    wr(MIC_GAIN_OFS, 8'hFF);
    rd_chk(MIC_GAIN_OFS, 8'hBF);
    wr(SPK_VOL_OFS, 8'hA5);
    rd_chk(SPK_VOL_OFS, 8'hA5);
    wr(8'h40, 8'h55);
    rd_chk(8'h40, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_spk;
    spk(8'h0C, 16'h1000, 16'h0000);
    spk(8'h80, 16'h1000, 16'h1000);
    spk(8'h8C, 16'h1000, 16'h2000);
    spk(8'hE8, 16'h1000, 16'h0400);
    spk(8'hDC, 16'h1000, 16'h0100);
    spk(8'hD4, 16'h4000, 16'h0196);
    spk(8'h8C, 16'h7000, 16'h7FFF);
    $display("test speaker done");
  endtask : t_spk

  task automatic t_mic;
    mic(8'h0C, 16'h1000, 16'h0000);
    mic(8'h80, 16'h1000, 16'h1000);
    mic(8'h8C, 16'h1000, 16'h2000);
    mic(8'hA7, 16'h0800, 16'h4C1C);
    mic(8'hFF, 16'h0800, 16'h4C1C);
    mic(8'h8C, 16'h8000, 16'h8000);
    $display("test mic done");
  endtask : t_mic

  // Firmware order: low byte, then high byte
  task automatic t_rec;
    logic [7:0] n;
    n = iso_cnt;
    wr(REC_LO_OFS, 8'h34);
    #1 chk("iso_cnt", {9'h000, n}, {9'h000, iso_cnt});
    @(posedge mclk);
    wr(REC_HI_OFS, 8'h12);
    #1 chk("iso_last", {1'b0, 16'h1234}, {1'b0, iso_last});
    @(posedge mclk);
    wr(REC_HI_OFS, 8'h56);
    #1 chk("iso_last", {1'b0, 16'h5634}, {1'b0, iso_last});
    chk("iso_cnt", {9'h000, n + 8'h02}, {9'h000, iso_cnt});
    @(posedge mclk);
    // Back-to-back pair, strobe held high across both writes
    reg_addr  <= REC_LO_OFS;
    reg_wdata <= 8'hCD;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_addr  <= REC_HI_OFS;
    reg_wdata <= 8'hAB;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
    #1 chk("iso_last", {1'b0, 16'hABCD}, {1'b0, iso_last});
    @(posedge mclk);
    rd_chk(REC_LO_OFS, 8'hCD);
    rd_chk(PUSH_CNT_OFS, 8'h03);
    $display("test record done");
  endtask : t_rec

  task automatic print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Watchdog, well past the roughly one hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    send      = 1'b0;
    send_data = 16'h0000;
    adc_in    = '0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_spk();
    t_mic();
    t_rec();
    print_verdict();
  end
endmodule : test_usb_audio_gain_mute_path
`default_nettype wire
